//--- laser_interlock_pwm_gate_defines.svh
// Constants for the laser interlock and PWM gating block.
`ifndef LASER_INTERLOCK_PWM_GATE_DEFINES_SVH
`define LASER_INTERLOCK_PWM_GATE_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock and timing figures, in their own units.
// ----------------------------------------------------------------------
`define MCLK_HZ          25000000
`define POWER_ON_DELAY_S 5
`define DEBOUNCE_US      1000
`define PHASE_TOL_NS     2000

// Derived cycle counts; each delay is rounded as its kind demands.
`define POWER_ON_DELAY_CYC (`POWER_ON_DELAY_S * `MCLK_HZ)
`define DEBOUNCE_CYC ((`DEBOUNCE_US * (`MCLK_HZ / 1000) + 999) / 1000)
`define PHASE_TOL_CYC ((`PHASE_TOL_NS * (`MCLK_HZ / 1000000)) / 1000)

// ----------------------------------------------------------------------
// Counter widths.
// ----------------------------------------------------------------------
`define DELAY_W 27
`define DEB_W   15
`define PHS_W   8

// ----------------------------------------------------------------------
// Input synchroniser indices; the first five are debounced.
// ----------------------------------------------------------------------
`define NSYNC     7
`define NDEB      5
`define IX_KEY    0
`define IX_SHUT   1
`define IX_OT     2
`define IX_OV     3
`define IX_PF     4
`define IX_MOD    5
`define IX_SENSE  6

// ----------------------------------------------------------------------
// Register map (byte addresses) and fields.
// ----------------------------------------------------------------------
`define ADDR_CTRL    8'h00
`define ADDR_STATUS  8'h04
`define ADDR_DELAY   8'h08
`define CTRL_RESET   2'h0
`define CTRL_PF_DIS  0
`define CTRL_FAIL_SUP 1
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

//--- laser_interlock_pwm_gate_pkg.sv
// Types shared by the laser interlock and PWM gating block.
`include "laser_interlock_pwm_gate_defines.svh"
package laser_interlock_pwm_gate_pkg;

  // Section power sequence.
  typedef enum logic [1:0] {
    ST_OFF,
    ST_DELAY,
    ST_RUN
  } seq_t;

  // Complete register state of the block.
  typedef struct packed {
    seq_t                                  seq;
    logic [`NSYNC-1:0]                     sync1;
    logic [`NSYNC-1:0]                     sync2;
    logic [`NDEB-1:0]                      deb;
    logic [`NDEB-1:0][`DEB_W-1:0]          deb_cnt;
    logic [`DELAY_W-1:0]                   delay_cnt;
    logic                                  delay_done;
    logic [`PHS_W-1:0]                     phs_cnt;
    logic                                  key_open_seen;
    logic                                  pf_lat;
    logic                                  ov_lat;
    logic                                  ot_lat;
    logic                                  fail_lat;
    logic                                  main_sw;
    logic                                  pwm_sw;
    logic                                  fault_n;
    logic                                  pwr_led;
    logic                                  lase_led;
    logic [1:0]                            ctrl;
    logic                                  aw_got;
    logic                                  w_got;
    logic [7:0]                            aw_addr;
    logic [31:0]                           w_data;
    logic                                  w_lane0;
    logic                                  awready;
    logic                                  wready;
    logic                                  bvalid;
    logic [1:0]                            bresp;
    logic                                  arready;
    logic                                  rvalid;
    logic [31:0]                           rdata;
    logic [1:0]                            rresp;
  } state_t;

endpackage

//--- laser_interlock_pwm_gate.sv
// Interlock, fault latching and PWM gating for one laser section.
`timescale 1ns/1ns
`include "laser_interlock_pwm_gate_defines.svh"
// ----------------------------------------------------------------------
// Contract
// - PWM switch follows modulation input while enabled
// - Delay, shutter or overtemp block modulation
// - Hold PWM off five seconds after power-on
// - Delay expiry removes the PWM disable
// - Closed shutter stops PWM, reopening resumes
// - Comparator high above 60C disables PWM
// - Overtemp latch opens main switch
// - Main on unless power fail, overvoltage, fault
// - Main switch on powers indicator, delay, PWM
// - Power-fail holds main off until key closes
// - Power-fail latch cleared only by key recycle (here also cleared while the power-fail function is disabled)
// - Option disables power-fail latch and fault
// - Above 36V latch main off until recycle
// - Every fault latch forces main switch off
// - OR of latches drives fault output low
// - Modulation versus PWM mismatch sets failure latch
// - Option suppresses failure shutdown, fault still shown
// - Each section has an independent logic copy
// - Lase indicator after delay, follows modulation
// ----------------------------------------------------------------------
module laser_interlock_pwm_gate #(
  parameter int unsigned DELAY_CYCLES = `POWER_ON_DELAY_CYC,
  parameter int unsigned DEB_CYCLES   = `DEBOUNCE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Interlock and sense pins, all asynchronous to mclk.
  input  wire logic        key_closed,
  input  wire logic        shutter_closed,
  input  wire logic        overtemp_hi,
  input  wire logic        overvolt_hi,
  input  wire logic        power_fail,
  input  wire logic        mod_in,
  input  wire logic        pwm_sense,
  // Switch and indicator drives.
  output logic             main_sw,
  output logic             pwm_sw,
  output logic             fault_n,
  output logic             pwr_led,
  output logic             lase_led,
  // AXI4-Lite register slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------------
  // State and derived constants.
  // ----------------------------------------------------------------------
  laser_interlock_pwm_gate_pkg::state_t r;   // Registered state.
  laser_interlock_pwm_gate_pkg::state_t nxt; // Next state.

  // Counts sized to their counters so compares stay width-clean.
  localparam logic [`DELAY_W-1:0] DELAY_LAST =
    `DELAY_W'(DELAY_CYCLES - 1);
  localparam logic [`DEB_W-1:0] DEB_LAST = `DEB_W'(DEB_CYCLES - 1);
  localparam logic [`PHS_W-1:0] PHS_LIMIT = `PHS_W'(`PHASE_TOL_CYC);

  // Raw pins gathered by synchroniser index.
  logic [`NSYNC-1:0] pins;
  assign pins[`IX_KEY]   = key_closed;
  assign pins[`IX_SHUT]  = shutter_closed;
  assign pins[`IX_OT]    = overtemp_hi;
  assign pins[`IX_OV]    = overvolt_hi;
  assign pins[`IX_PF]    = power_fail;
  assign pins[`IX_MOD]   = mod_in;
  assign pins[`IX_SENSE] = pwm_sense;

  // ----------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------
  // All behaviour lives here; the flops below only register it.
  // Nothing is shared with any other instance, so a dual-section build
  // simply places two instances and a fault in one leaves the other
  // running.
  always_comb begin
    logic       key_ok;      // Debounced key and interlock closed.
    logic       shut;        // Debounced shutter closed.
    logic       ot;          // Debounced overtemperature comparator.
    logic       ov;          // Debounced overvoltage detect.
    logic       pf;          // Debounced input power failure.
    logic       recycle;     // Key seen open and now closed again.
    logic       pf_en;       // Power-fail function in use.
    logic       fail_sd;     // Failure latch may open the main switch.
    logic       main_en;     // Main switch may be closed.
    logic       pwm_en;      // PWM gating enabled.
    logic       aw_hs;       // Write address taken this cycle.
    logic       w_hs;        // Write data taken this cycle.
    logic       ar_hs;       // Read address taken this cycle.
    logic [7:0] ar_addr;     // Read address.
    key_ok  = 1'b0;
    shut    = 1'b0;
    ot      = 1'b0;
    ov      = 1'b0;
    pf      = 1'b0;
    recycle = 1'b0;
    pf_en   = 1'b0;
    fail_sd = 1'b0;
    main_en = 1'b0;
    pwm_en  = 1'b0;
    aw_hs   = 1'b0;
    w_hs    = 1'b0;
    ar_hs   = 1'b0;
    ar_addr = 8'h00;
    nxt     = r;

    // Two-flop synchronisers; stage one feeds stage two only.
    nxt.sync1 = pins;
    nxt.sync2 = r.sync1;

    // Debounce: a level is accepted after it has stood unchanged for
    // the full debounce time. Modulation and sense are not filtered,
    // since a filter would eat the narrow tickle pulses.
    for (int i = 0; i < `NDEB; i++) begin
      if (r.sync2[i] == r.deb[i]) begin
        nxt.deb_cnt[i] = '0;
      end else if (r.deb_cnt[i] == DEB_LAST) begin
        nxt.deb[i]     = r.sync2[i];
        nxt.deb_cnt[i] = '0;
      end else begin
        nxt.deb_cnt[i] = r.deb_cnt[i] + `DEB_W'(1);
      end
    end

    key_ok = r.deb[`IX_KEY];
    shut   = r.deb[`IX_SHUT];
    ot     = r.deb[`IX_OT];
    ov     = r.deb[`IX_OV];
    pf     = r.deb[`IX_PF];
    pf_en  = ~r.ctrl[`CTRL_PF_DIS];
    fail_sd = ~r.ctrl[`CTRL_FAIL_SUP];

    // Key recycle: an open level must be seen before a close counts.
    // It clears all the latches below; the power-fail latch also clears when its function is disabled.
    if (!key_ok) begin
      nxt.key_open_seen = 1'b1;
    end else if (r.key_open_seen) begin
      nxt.key_open_seen = 1'b0;
      recycle           = 1'b1;
    end

    // Fault latches. A set in the recycle cycle wins over the clear,
    // so an event arriving together with the recycle is never lost.
    // Power fail is caught only while the main switch is closed and only when the
    // function is in use.
    nxt.pf_lat = (r.pf_lat & ~recycle & pf_en) |
                 (pf & r.main_sw & pf_en);
    // Overvoltage latches off regardless of state.
    nxt.ov_lat = (r.ov_lat & ~recycle) | ov;
    // Overtemperature comparator high sets its latch.
    nxt.ot_lat = (r.ot_lat & ~recycle) | ot;

    // Phase check: the driven PWM level is compared with the sensed
    // switch output; a mismatch standing longer than the tolerance
    // points to a failed switch, driver or amplifier. The window
    // also absorbs the two synchroniser cycles of the sense.
    if (!r.main_sw || (r.pwm_sw == r.sync2[`IX_SENSE])) begin
      nxt.phs_cnt = '0;
    end else if (r.phs_cnt != PHS_LIMIT) begin
      nxt.phs_cnt = r.phs_cnt + `PHS_W'(1);
    end
    nxt.fail_lat = (r.fail_lat & ~recycle) |
                   (r.main_sw && r.phs_cnt == PHS_LIMIT);

    // Main switch: needs the key closed, so a power-fail reset holds
    // it open until the key closes; any latch forces it open, except
    // the failure latch when its shutdown is suppressed.
    main_en = key_ok & ~r.pf_lat & ~r.ov_lat & ~r.ot_lat &
              ~(r.fail_lat & fail_sd);
    nxt.main_sw = main_en;

    // Power sequence: main switch closure starts the delay; the delay
    // restarts whenever the main switch opens.
    case (r.seq)
      laser_interlock_pwm_gate_pkg::ST_OFF: begin
        nxt.delay_cnt  = '0;
        nxt.delay_done = 1'b0;
        if (r.main_sw) begin
          nxt.seq = laser_interlock_pwm_gate_pkg::ST_DELAY;
        end
      end
      laser_interlock_pwm_gate_pkg::ST_DELAY: begin
        if (!r.main_sw) begin
          nxt.seq = laser_interlock_pwm_gate_pkg::ST_OFF;
        end else if (r.delay_cnt == DELAY_LAST) begin
          // Time-out lowers the delay disable.
          nxt.delay_done = 1'b1;
          nxt.seq        = laser_interlock_pwm_gate_pkg::ST_RUN;
        end else begin
          nxt.delay_cnt = r.delay_cnt + `DELAY_W'(1);
        end
      end
      laser_interlock_pwm_gate_pkg::ST_RUN: begin
        if (!r.main_sw) begin
          nxt.delay_done = 1'b0;
          nxt.seq        = laser_interlock_pwm_gate_pkg::ST_OFF;
        end
      end
      default: begin
        nxt.seq = laser_interlock_pwm_gate_pkg::ST_OFF;
      end
    endcase

    // PWM gating: any of the three disables being high blocks the
    // modulation; otherwise the switch follows it edge for edge, three
    // cycles late (two synchroniser flops and the output flop). The shutter disable is a level, so output
    // resumes once it falls; the comparator also latches and needs a recycle.
    pwm_en     = r.main_sw & r.delay_done & ~shut & ~ot;
    nxt.pwm_sw = pwm_en & r.sync2[`IX_MOD];

    // Indicators: power LED with the main switch; lase LED only once
    // the delay is over, pulsing with the modulation so its brightness
    // tracks duty cycle.
    nxt.pwr_led  = r.main_sw;
    nxt.lase_led = r.main_sw & r.delay_done & r.sync2[`IX_MOD];

    // Fault output low while any latch is set; the failure latch shows
    // even when its shutdown is suppressed.
    nxt.fault_n = ~(r.pf_lat | r.ov_lat | r.ot_lat | r.fail_lat);

    // --------------------------------------------------------------------
    // AXI4-Lite write path.
    // --------------------------------------------------------------------
    // Address and data are taken independently, each ready dropping
    // after its handshake, and the response follows both.
    aw_hs = s_axi_awvalid & r.awready;
    w_hs  = s_axi_wvalid & r.wready;
    if (aw_hs) begin
      nxt.aw_got  = 1'b1;
      nxt.aw_addr = s_axi_awaddr;
      nxt.awready = 1'b0;
    end
    if (w_hs) begin
      nxt.w_got   = 1'b1;
      nxt.w_data  = s_axi_wdata;
      nxt.w_lane0 = s_axi_wstrb[0];
      nxt.wready  = 1'b0;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      nxt.aw_got = 1'b0;
      nxt.w_got  = 1'b0;
      nxt.bvalid = 1'b1;
      // Only the control word is writable; its bits sit in lane 0.
      if (r.aw_addr == `ADDR_CTRL) begin
        if (r.w_lane0) begin
          nxt.ctrl = r.w_data[1:0];
        end
        nxt.bresp = `RESP_OKAY;
      end else if (r.aw_addr == `ADDR_STATUS ||
                   r.aw_addr == `ADDR_DELAY) begin
        // Read-only words ignore the data but answer cleanly.
        nxt.bresp = `RESP_OKAY;
      end else begin
        nxt.bresp = `RESP_SLVERR;
      end
    end
    if (r.bvalid && s_axi_bready) begin
      nxt.bvalid  = 1'b0;
      nxt.awready = 1'b1;
      nxt.wready  = 1'b1;
    end

    // --------------------------------------------------------------------
    // AXI4-Lite read path.
    // --------------------------------------------------------------------
    // One read at a time: arready stays low until the data is taken.
    ar_hs   = s_axi_arvalid & r.arready;
    ar_addr = s_axi_araddr;
    if (ar_hs) begin
      nxt.arready = 1'b0;
      nxt.rvalid  = 1'b1;
      nxt.rresp   = `RESP_OKAY;
      if (ar_addr == `ADDR_CTRL) begin
        nxt.rdata = {30'h0, r.ctrl};
      end else if (ar_addr == `ADDR_STATUS) begin
        nxt.rdata = {22'h0, key_ok, shut, ~r.fault_n, r.fail_lat,
                     r.ot_lat, r.ov_lat, r.pf_lat, r.pwm_sw,
                     r.delay_done, r.main_sw};
      end else if (ar_addr == `ADDR_DELAY) begin
        nxt.rdata = {5'h0, r.delay_cnt};
      end else begin
        nxt.rdata = 32'h0;
        nxt.rresp = `RESP_SLVERR;
      end
    end
    if (r.rvalid && s_axi_rready) begin
      nxt.rvalid  = 1'b0;
      nxt.arready = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  // Reset opens both switches and shows no fault; the bus is ready at
  // once. Debounced levels reset to open/inactive, so a key held
  // closed through reset still has to be qualified before power-up.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r               <= '0;
      r.seq           <= laser_interlock_pwm_gate_pkg::ST_OFF;
      r.fault_n       <= 1'b1;
      r.ctrl          <= `CTRL_RESET;
      r.awready       <= 1'b1;
      r.wready        <= 1'b1;
      r.arready       <= 1'b1;
      r.key_open_seen <= 1'b0;
    end else begin
      r <= nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, straight from the state flops.
  // ----------------------------------------------------------------------
  assign main_sw       = r.main_sw;
  assign pwm_sw        = r.pwm_sw;
  assign fault_n       = r.fault_n;
  assign pwr_led       = r.pwr_led;
  assign lase_led      = r.lase_led;
  assign s_axi_awready = r.awready;
  assign s_axi_wready  = r.wready;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;

endmodule

//--- laser_gate_checker_assertions.sv
// Port-level property checks for the laser interlock and PWM gate.
`timescale 1ns/1ns
module laser_gate_checker #(
  parameter int unsigned DELAY_CYCLES = 100,
  parameter int unsigned DEB_CYCLES   = 4
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        key_closed,
  input wire logic        shutter_closed,
  input wire logic        overtemp_hi,
  input wire logic        overvolt_hi,
  input wire logic        mod_in,
  input wire logic        main_sw,
  input wire logic        pwm_sw,
  input wire logic        fault_n,
  input wire logic        pwr_led,
  input wire logic        lase_led,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // ------------------------------------------------------------
  // Helper counters.
  // ------------------------------------------------------------
  logic [3:0]  cond;     // Pin conditions whose runs are counted.
  int unsigned run_r[4]; // Consecutive cycles each condition held.
  int unsigned on_r;     // Cycles the main switch has been closed.
  assign cond = {!key_closed, shutter_closed, overtemp_hi, overvolt_hi};
  // The margin covers the synchroniser, filter and output registers.
  // Runs are counted on sampled pins, so they never over-credit time.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      on_r <= 0;
      for (int i = 0; i < 4; i++) run_r[i] <= 0;
    end else begin
      on_r <= main_sw ? on_r + 1 : 0;
      for (int i = 0; i < 4; i++) run_r[i] <= cond[i] ? run_r[i] + 1 : 0;
    end
  end
  // ------------------------------------------------------------
  // Properties.
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_pwm_follows_mod: assert property (pwm_sw |-> $past(mod_in, 3))
    else $error("pwm switch on without modulation");
  a_pwm_after_delay: assert property (pwm_sw |-> on_r >= DELAY_CYCLES)
    else $error("pwm switch on before delay");
  a_pwm_needs_main: assert property (pwm_sw |-> $past(main_sw))
    else $error("pwm switch on with main open");
  a_lase_after_delay: assert property (lase_led |-> on_r >= DELAY_CYCLES)
    else $error("lase indicator before delay");
  a_pwr_led_main: assert property ($stable(main_sw) |-> pwr_led == main_sw)
    else $error("power indicator differs from main");
  a_shutter_block: assert property (run_r[2] >= DEB_CYCLES + 6 |-> !pwm_sw)
    else $error("pwm on with shutter closed");
  a_ot_block: assert property (run_r[1] >= DEB_CYCLES + 6 |-> !pwm_sw)
    else $error("pwm on during overtemp");
  a_ov_trip: assert property (run_r[0] >= DEB_CYCLES + 8 |-> !main_sw && !fault_n)
    else $error("overvoltage did not trip");
  a_key_open_off: assert property (run_r[3] >= DEB_CYCLES + 8 |-> !main_sw)
    else $error("main closed with key open");
  a_fault_holds: assert property ($fell(fault_n) |-> !fault_n [*3])
    else $error("fault output did not hold");
  a_main_clean: assert property ($rose(main_sw) |=> fault_n)
    else $error("main closed with a fault latched");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  c_pwm_on: cover property (pwm_sw);
  c_fault_main_on: cover property ($fell(fault_n) && main_sw);
  c_main_up: cover property ($rose(main_sw));
endmodule

bind laser_interlock_pwm_gate laser_gate_checker #(
  .DELAY_CYCLES(DELAY_CYCLES), .DEB_CYCLES(DEB_CYCLES)) chk_i (.*);

//--- mod_source.sv
// Model of the external modulation source and switch sense wiring.
`timescale 1ns/1ns
module mod_source (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       pwm_sw,
  input  wire logic [7:0] hi_len,
  input  wire logic [7:0] lo_len,
  input  wire logic       sense_bad,
  output logic            mod_in,
  output logic            pwm_sense
);
  logic [7:0] cnt_r; // Cycles left in the present phase.
  // Square wave; high phases never shorter than one microsecond.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 8'h00;
      mod_in <= 1'b0;
    end else if (cnt_r == 8'h00) begin
      mod_in <= !mod_in;
      cnt_r  <= mod_in ? lo_len : (hi_len < 8'h19 ? 8'h19 : hi_len);
    end else begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  // A healthy switch echoes its drive; a broken one reads opposite.
  assign pwm_sense = sense_bad ? !pwm_sw : pwm_sw;
endmodule

//--- tb.sv
// Self-checking bench for the laser interlock and PWM gate.
`timescale 1ns/1ns
`include "laser_interlock_pwm_gate_defines.svh"
module tb;
  // ------------------------------------------------------------
  // Signals.
  // ------------------------------------------------------------
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  pin = 5'h00;   // {pf, ov, ot, shutter, key}.
  logic        sense_bad = 1'b0;
  logic [7:0]  hi_len = 8'h20;
  logic [7:0]  lo_len = 8'h10;
  logic [7:0]  aa = 8'h00;
  logic [31:0] wd = 32'h0;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        br = 1'b0;
  logic        arv = 1'b0;
  logic        rr = 1'b0;
  logic        mod_in, pwm_sense, main_sw, pwm_sw, fault_n, pwr_led;
  logic        lase_led, awr, wrd, bv, arr, rv;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] seed = 32'h00016D36; // Xorshift state, fixed start.
  logic [3:0]  lat = 4'h0;          // Expected latches {fail,ot,ov,pf}.
  logic [1:0]  ctrl = 2'h0;         // Shadow of the control register.
  logic [2:0]  mh = 3'h0;           // Recent modulation samples.
  int          err_count = 0;
  int          check_count = 0;

  laser_interlock_pwm_gate #(.DELAY_CYCLES(100), .DEB_CYCLES(4)) uut (
    .mclk, .rst_n, .key_closed(pin[0]), .shutter_closed(pin[1]),
    .overtemp_hi(pin[2]), .overvolt_hi(pin[3]), .power_fail(pin[4]),
    .mod_in, .pwm_sense, .main_sw, .pwm_sw, .fault_n, .pwr_led, .lase_led,
    .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(aa), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr));
  mod_source far (.mclk, .rst_n, .pwm_sw, .hi_len, .lo_len, .sense_bad,
    .mod_in, .pwm_sense);

  always #20 mclk = !mclk;
  // The gate output should equal modulation from three samples back.
  always @(posedge mclk) mh <= {mh[1:0], mod_in};

  // ------------------------------------------------------------
  // Helpers.
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Main closes on the key unless a latch, or an unsuppressed failure.
  function automatic logic exp_main(input logic [3:0] l, input logic k,
                                    input logic sup);
    return k & !(|l[2:0]) & !(l[3] & !sup);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus transfer; ready and answer are sampled before each edge.
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
    logic fa, fw, fr, fb;
    @(posedge mclk);
    aa <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    br <= w;
    arv <= !w;
    rr <= !w;
    fb = 1'b0;
    while (!fb) begin
      @(negedge mclk);
      fa = awr;
      fw = wrd;
      fr = arr;
      fb = w ? bv : rv;
      q = rdata;
      r = w ? bresp : rresp;
      @(posedge mclk);
      if (fa) awv <= 1'b0;
      if (fw) wv <= 1'b0;
      if (fr) arv <= 1'b0;
    end
    br <= 1'b0;
    rr <= 1'b0;
  endtask
  task automatic setctrl(input logic [1:0] c);
    logic [31:0] q;
    logic [1:0]  r;
    xfer(1'b1, `ADDR_CTRL, {30'h0, c}, q, r);
    ctrl = c;
    chk(r, `RESP_OKAY);
  endtask
  // Let pins filter through, then compare main switch, fault output and latch status.
  task automatic settle();
    logic [31:0] q;
    logic [1:0]  r;
    tick(20);
    chk(main_sw, exp_main(lat, pin[0], ctrl[1]));
    chk(fault_n, !(|lat));
    xfer(1'b0, `ADDR_STATUS, 32'h0, q, r);
    chk(q[6:3], lat);
  endtask
  task automatic follow(input logic en);
    repeat (40) begin
      @(negedge mclk);
      chk(pwm_sw, en & mh[2]);
    end
    @(posedge mclk);
  endtask
  task automatic pulse(input int i, input int n);
    pin[i] <= 1'b1;
    tick(n);
    pin[i] <= 1'b0;
  endtask
  task automatic recycle();
    pin[0] <= 1'b0;
    tick(15);
    pin[0] <= 1'b1;
    lat = 4'h0;
    settle();
  endtask
  task automatic end_sim();
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  initial begin
    logic [31:0] q, d;
    logic [1:0]  r;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    xfer(1'b0, `ADDR_CTRL, 32'h0, q, r);
    chk(q, 32'h0);
    xfer(1'b1, 8'h0C, 32'h3, q, r);
    chk(r, `RESP_SLVERR);
    xfer(1'b0, 8'h0C, 32'h0, q, r);
    chk(q, 32'h0);
    chk(r, `RESP_SLVERR);
    xfer(1'b1, `ADDR_STATUS, 32'hFF, q, r);
    chk(r, `RESP_OKAY);
    repeat (4) begin
      d = rnd();
      xfer(1'b1, `ADDR_CTRL, d, q, r);
      xfer(1'b0, `ADDR_CTRL, 32'h0, q, r);
      chk(q, {30'h0, d[1:0]});
    end
    setctrl(2'h0);
    d = rnd();
    hi_len <= 8'h19 + {4'h0, d[3:0]};
    lo_len <= 8'h03 + {4'h0, d[7:4]};
    pin[0] <= 1'b1;
    settle();
    chk(pwr_led, 1'b1);
    follow(1'b0);
    tick(80);
    follow(1'b1);
    pin[1] <= 1'b1;
    tick(12);
    follow(1'b0);
    pin[1] <= 1'b0;
    tick(12);
    follow(1'b1);
    pin[2] <= 1'b1;
    tick(12);
    follow(1'b0);
    pin[2] <= 1'b0;
    lat[2] = 1'b1;
    settle();
    recycle();
    follow(1'b0);
    pulse(3, 2);
    settle();
    pulse(3, 12);
    lat[1] = 1'b1;
    settle();
    recycle();
    pulse(4, 12);
    lat[0] = 1'b1;
    settle();
    recycle();
    setctrl(2'h1);
    pulse(4, 12);
    settle();
    recycle();
    setctrl(2'h0);
    tick(100);
    pin[1] <= 1'b1;
    sense_bad <= 1'b1;
    tick(80);
    sense_bad <= 1'b0;
    lat[3] = 1'b1;
    settle();
    recycle();
    setctrl(2'h2);
    sense_bad <= 1'b1;
    tick(70);
    sense_bad <= 1'b0;
    lat[3] = 1'b1;
    settle();
    recycle();
    end_sim();
  end

  initial begin
    #400000;
    err_count++;
    end_sim();
  end
endmodule
